// ---- src/ovs_link.sv ----
// one-pin voltage-set link: mode select, bit decoder, acknowledge, APB registers
`timescale 1ns/1ns
module ovs_link #(
	parameter int unsigned TIMEOUT_CYC     = ovs_pkg::TIMEOUT_CYC,
	parameter int unsigned REPLY_PULSE_CYC = ovs_pkg::REPLY_PULSE_CYC,
	parameter int unsigned REPLY_DELAY_CYC = ovs_pkg::REPLY_DELAY_CYC,
	parameter int unsigned BUF_DEPTH       = 2
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          mode_data_in,
	output logic               mode_data_out,
	output logic               mode_data_oe,
	output logic               forced_pwm,
	output ovs_pkg::ovs_settings_t settings
);
	localparam logic [ovs_pkg::CNT_W-1:0] TMO = ovs_pkg::CNT_W'(TIMEOUT_CYC);
	localparam logic [ovs_pkg::CNT_W-1:0] PULSE = ovs_pkg::CNT_W'(REPLY_PULSE_CYC);
	localparam logic [ovs_pkg::CNT_W-1:0] DLY = ovs_pkg::CNT_W'(REPLY_DELAY_CYC);
	localparam logic [4:0] NBITS = 5'(ovs_pkg::FRAME_BITS);
	localparam logic [4:0] NBYTE = 5'(ovs_pkg::BYTE_BITS);

	ovs_pkg::ovs_state_t        state_reg;
	logic                       sync1_reg;
	logic                       sync2_reg;
	logic                       pin_prev_reg;
	logic [ovs_pkg::CNT_W-1:0]  lo_reg;
	logic [ovs_pkg::CNT_W-1:0]  hi_reg;
	logic [ovs_pkg::CNT_W-1:0]  tmr_reg;
	logic [4:0]                 nbit_reg;
	logic                       gap_reg;
	logic                       bad_reg;
	logic [15:0]                shift_reg;
	logic                       pwm_reg;
	logic                       en_reg;
	logic [7:0]                 id_reg;
	logic                       err_reg;
	logic                       ovf_reg;
	logic                       acked_reg;
	ovs_pkg::ovs_settings_t     set_reg;
	logic [31:0]                rdata_reg;
	logic                       fall;
	logic                       low_tmo;
	logic                       bit_one;
	logic                       bit_zero;
	logic                       last_bit;
	logic                       frame_done;
	logic                       frame_ok;
	logic [15:0]                frame_word;
	ovs_pkg::ovs_frame_t        frame;
	logic                       buf_in_ready;
	logic                       buf_out_valid;
	ovs_pkg::ovs_frame_t        buf_out_data;
	logic                       wr_acc;
	logic                       rd_acc;
	logic                       mapped;

	// the pin is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg    <= 1'b1;
			sync2_reg    <= 1'b1;
			pin_prev_reg <= 1'b1;
		end
		else
		begin
			sync1_reg    <= mode_data_in;
			sync2_reg    <= sync1_reg;
			pin_prev_reg <= sync2_reg;
		end
	end

	assign fall     = pin_prev_reg && !sync2_reg;
	assign low_tmo  = !sync2_reg && (lo_reg >= TMO - 1'b1);
	assign bit_one  = (hi_reg >= {lo_reg[ovs_pkg::CNT_W-2:0], 1'b0}) && (hi_reg != '0);
	assign bit_zero = (lo_reg >= {hi_reg[ovs_pkg::CNT_W-2:0], 1'b0}) && (lo_reg != '0);
	assign last_bit = (nbit_reg == NBITS - 5'h01);
	assign frame_done = (state_reg == ovs_pkg::OVS_RX) && fall && !gap_reg && last_bit;
	assign frame_word = {shift_reg[14:0], bit_one};
	assign frame    = ovs_pkg::ovs_frame_t'(frame_word[7:0]);
	assign frame_ok = frame_done && !bad_reg && (bit_one || bit_zero)
		&& (frame_word[15:8] == id_reg);

	// bit timing and frame sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ovs_pkg::OVS_IDLE;
			lo_reg    <= '0;
			hi_reg    <= '0;
			tmr_reg   <= '0;
			nbit_reg  <= '0;
			gap_reg   <= 1'b0;
			bad_reg   <= 1'b0;
			shift_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				ovs_pkg::OVS_IDLE:
				begin
					lo_reg   <= '0;
					hi_reg   <= '0;
					nbit_reg <= '0;
					gap_reg  <= 1'b0;
					bad_reg  <= 1'b0;
					if (fall && en_reg)
						state_reg <= ovs_pkg::OVS_RX;
				end
				ovs_pkg::OVS_RX:
				begin
					if (low_tmo)
						state_reg <= ovs_pkg::OVS_IDLE;
					else if (fall)
					begin
						lo_reg <= '0;
						hi_reg <= '0;
						if (gap_reg)
							// the byte close interval carries no bit
							gap_reg <= 1'b0;
						else
						begin
							shift_reg <= frame_word;
							if (!(bit_one || bit_zero))
								bad_reg <= 1'b1;
							nbit_reg <= nbit_reg + 5'h01;
							gap_reg  <= (nbit_reg == NBYTE - 5'h01);
							if (last_bit)
							begin
								tmr_reg   <= '0;
								state_reg <= (frame_ok && frame.ack_request_bit)
									? ovs_pkg::OVS_WAIT : ovs_pkg::OVS_IDLE;
							end
						end
					end
					else if (sync2_reg)
						hi_reg <= (&hi_reg) ? hi_reg : hi_reg + 1'b1;
					else
						lo_reg <= lo_reg + 1'b1;
				end
				ovs_pkg::OVS_WAIT:
				begin
					tmr_reg <= tmr_reg + 1'b1;
					if (tmr_reg >= DLY - 1'b1)
					begin
						tmr_reg   <= '0;
						state_reg <= ovs_pkg::OVS_ACK;
					end
				end
				ovs_pkg::OVS_ACK:
				begin
					tmr_reg <= tmr_reg + 1'b1;
					if (tmr_reg >= PULSE - 1'b1)
					begin
						lo_reg    <= '0;
						state_reg <= ovs_pkg::OVS_IDLE;
					end
				end
			endcase
			// idle low time also runs toward the limit
			if (state_reg == ovs_pkg::OVS_IDLE && !sync2_reg && !low_tmo)
				lo_reg <= lo_reg + 1'b1;
		end
	end

	// open-drain pull-down only, never drives high
	assign mode_data_out = 1'b0;
	assign mode_data_oe  = (state_reg == ovs_pkg::OVS_ACK);

	// operating mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwm_reg <= 1'b0;
		else if (sync2_reg && state_reg != ovs_pkg::OVS_ACK)
			pwm_reg <= 1'b1;
		else if (low_tmo && state_reg != ovs_pkg::OVS_ACK)
			// only the long low ends it, never a bit
			pwm_reg <= 1'b0;
	end

	assign forced_pwm = pwm_reg;

	// setting registers, updated only from a good frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			set_reg <= '{ovs_pkg::SET_RST, ovs_pkg::SET_RST, ovs_pkg::SET_RST};
		else if (frame_ok)
		begin
			unique case (frame.target_select)
				2'b00: set_reg.set0 <= frame.setting;
				2'b01: set_reg.set1 <= frame.setting;
				2'b10: set_reg.set2 <= frame.setting;
				2'b11: set_reg <= set_reg;
			endcase
		end
	end

	assign settings = set_reg;

	ovs_buf #(
		.WIDTH ($bits(ovs_pkg::ovs_frame_t)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (frame_ok),
		.in_ready  (buf_in_ready),
		.in_data   (frame),
		.out_valid (buf_out_valid),
		.out_ready (rd_acc && paddr == ovs_pkg::OFF_FRAME),
		.out_data  (buf_out_data)
	);

	// APB slave, zero wait states
	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign mapped  = (paddr == ovs_pkg::OFF_CTRL) || (paddr == ovs_pkg::OFF_STATUS)
		|| (paddr == ovs_pkg::OFF_SET0) || (paddr == ovs_pkg::OFF_SET1)
		|| (paddr == ovs_pkg::OFF_SET2) || (paddr == ovs_pkg::OFF_FRAME);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = rdata_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_reg <= ovs_pkg::CTRL_EN_RST;
			id_reg <= ovs_pkg::DEV_ID_RST;
		end
		else if (wr_acc && paddr == ovs_pkg::OFF_CTRL)
		begin
			en_reg <= pwdata[ovs_pkg::CTRL_EN_BIT];
			id_reg <= pwdata[ovs_pkg::CTRL_ID_LSB +: 8];
		end
	end

	// sticky flags: a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_reg   <= 1'b0;
			ovf_reg   <= 1'b0;
			acked_reg <= 1'b0;
		end
		else
		begin
			if (frame_done && !frame_ok)
				err_reg <= 1'b1;
			else if (wr_acc && paddr == ovs_pkg::OFF_STATUS && pwdata[ovs_pkg::ST_ERR_BIT])
				err_reg <= 1'b0;
			if (frame_ok && !buf_in_ready)
				ovf_reg <= 1'b1;
			else if (wr_acc && paddr == ovs_pkg::OFF_STATUS && pwdata[ovs_pkg::ST_OVF_BIT])
				ovf_reg <= 1'b0;
			if (state_reg == ovs_pkg::OVS_ACK)
				acked_reg <= 1'b1;
			else if (wr_acc && paddr == ovs_pkg::OFF_STATUS && pwdata[ovs_pkg::ST_ACK_BIT])
				acked_reg <= 1'b0;
		end
	end

	// read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_reg <= '0;
		else if (psel && !penable)
		begin
			rdata_reg <= '0;
			unique case (paddr)
				ovs_pkg::OFF_CTRL:
					rdata_reg <= {16'h0000, id_reg, 7'h00, en_reg};
				ovs_pkg::OFF_STATUS:
					rdata_reg <= {26'h0000000, acked_reg, buf_out_valid, ovf_reg, err_reg,
						(state_reg != ovs_pkg::OVS_IDLE), pwm_reg};
				ovs_pkg::OFF_SET0: rdata_reg <= {27'h0000000, set_reg.set0};
				ovs_pkg::OFF_SET1: rdata_reg <= {27'h0000000, set_reg.set1};
				ovs_pkg::OFF_SET2: rdata_reg <= {27'h0000000, set_reg.set2};
				ovs_pkg::OFF_FRAME:
					rdata_reg <= {23'h000000, buf_out_valid,
						(buf_out_valid ? 8'(buf_out_data) : 8'h00)};
				default: rdata_reg <= '0;
			endcase
		end
	end
endmodule : ovs_link

// ---- src/ovs_pkg.sv ----
// shared constants and types of the one-pin voltage-set link receiver
package ovs_pkg;
	// clock rate in MHz, period 8 ns
	localparam int unsigned CLK_MHZ = 125;
	// longest acknowledge pull-down, microseconds
	localparam int unsigned REPLY_PULSE_US = 520;
	localparam int unsigned REPLY_PULSE_CYC = REPLY_PULSE_US * CLK_MHZ;
	// delay from last falling edge to acknowledge, microseconds
	localparam int unsigned REPLY_DELAY_US = 2;
	localparam int unsigned REPLY_DELAY_CYC = REPLY_DELAY_US * CLK_MHZ;
	// idle-low limit that ends decoding, microseconds
	localparam int unsigned TIMEOUT_US = 1000;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int unsigned CNT_W = 18;
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned BYTE_BITS = 8;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_SET0 = 8'h08;
	localparam logic [7:0] OFF_SET1 = 8'h0c;
	localparam logic [7:0] OFF_SET2 = 8'h10;
	localparam logic [7:0] OFF_FRAME = 8'h14;

	// control fields
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_ID_LSB = 8;
	// status fields
	localparam int unsigned ST_PWM_BIT = 0;
	localparam int unsigned ST_BUSY_BIT = 1;
	localparam int unsigned ST_ERR_BIT = 2;
	localparam int unsigned ST_OVF_BIT = 3;
	localparam int unsigned ST_AVAIL_BIT = 4;
	localparam int unsigned ST_ACK_BIT = 5;

	// reset values; the id value is arbitrary
	localparam logic [7:0] DEV_ID_RST = 8'h5a;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [4:0] SET_RST = 5'h00;

	typedef struct packed {
		logic       ack_request_bit;
		logic [1:0] target_select;
		logic [4:0] setting;
	} ovs_frame_t;

	typedef struct packed {
		logic [4:0] set0;
		logic [4:0] set1;
		logic [4:0] set2;
	} ovs_settings_t;

	typedef enum logic [1:0] {
		OVS_IDLE,
		OVS_RX,
		OVS_WAIT,
		OVS_ACK
	} ovs_state_t;
endpackage : ovs_pkg

// ---- src/ovs_buf.sv ----
// small valid/ready buffer for received frames
`timescale 1ns/1ns
module ovs_buf #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_L = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != DEPTH_L);
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge pclk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : ovs_buf

// ---- tb/ovs_link_properties.sv ----
// concurrent checks on the pin side of the link receiver
`timescale 1ns/1ns
module ovs_link_properties #(
	parameter int unsigned TIMEOUT_CYC     = 400,
	parameter int unsigned REPLY_PULSE_CYC = 50,
	parameter int unsigned REPLY_DELAY_CYC = 10
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   mode_data_in,
	input wire logic                   mode_data_out,
	input wire logic                   mode_data_oe,
	input wire logic                   forced_pwm,
	input wire ovs_pkg::ovs_settings_t settings
);
	logic [31:0] lo_cnt;
	logic [31:0] oe_cnt;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// raw pin low run; the design sees it two syncs later
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lo_cnt <= 32'h0;
		else if (mode_data_in)
			lo_cnt <= 32'h0;
		else
			lo_cnt <= lo_cnt + 32'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oe_cnt <= 32'h0;
		else if (mode_data_oe)
			oe_cnt <= oe_cnt + 32'h1;
		else
			oe_cnt <= 32'h0;
	end

	pin_high_pwm_a: assert property (mode_data_in [*5] |-> forced_pwm)
		else $error("power-save kept while pin high");
	timeout_save_a: assert property (lo_cnt == TIMEOUT_CYC + 8 |-> !forced_pwm)
		else $error("no timeout after long low");
	pwm_hold_rx_a: assert property ($fell(forced_pwm) |-> lo_cnt >= TIMEOUT_CYC)
		else $error("forced mode dropped early");
	oe_low_only_a: assert property (mode_data_oe |-> !mode_data_out && forced_pwm)
		else $error("pin driven high or forced mode lost in reply");
	ack_pulse_len_a: assert property ($fell(mode_data_oe) |-> oe_cnt == REPLY_PULSE_CYC)
		else $error("acknowledge length wrong");
	ack_max_len_a: assert property (oe_cnt <= REPLY_PULSE_CYC)
		else $error("acknowledge too long");
	ack_after_edge_a: assert property ($rose(mode_data_oe) |-> !$past(mode_data_in, REPLY_DELAY_CYC))
		else $error("acknowledge without falling edge");
	set_on_edge_a: assert property (!$stable(settings) |-> !$past(mode_data_in))
		else $error("settings changed off frame end");
endmodule : ovs_link_properties

bind ovs_link ovs_link_properties #(
	.TIMEOUT_CYC(TIMEOUT_CYC),
	.REPLY_PULSE_CYC(REPLY_PULSE_CYC),
	.REPLY_DELAY_CYC(REPLY_DELAY_CYC)
) i_props (
	.pclk(pclk),
	.presetn(presetn),
	.mode_data_in(mode_data_in),
	.mode_data_out(mode_data_out),
	.mode_data_oe(mode_data_oe),
	.forced_pwm(forced_pwm),
	.settings(settings)
);

// ---- tb/ovs_master.sv ----
// pin master model: open-drain pull-down sending width-coded frames
`timescale 1ns/1ns
module ovs_master (
	input wire logic pclk,
	output logic     pull_low
);
	initial pull_low = 1'b0;

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc

	// one is short low, zero long low; eq gives an undecidable bit
	task automatic send_bits(input logic [7:0] b, input int eq);
		for (int i = 7; i >= 0; i--)
		begin
			pull_low <= 1'b1;
			wait_cyc(eq ? 20 : (b[i] ? 10 : 30));
			pull_low <= 1'b0;
			wait_cyc(eq ? 20 : (b[i] ? 30 : 10));
		end
	endtask : send_bits

	// start, address first, closes, open-drain only
	task automatic send_frame(input logic [7:0] a, input logic [7:0] d, input int eq);
		pull_low <= 1'b0;
		wait_cyc(40);
		send_bits(a, 0);
		pull_low <= 1'b1;
		wait_cyc(40);
		pull_low <= 1'b0;
		wait_cyc(40);
		send_bits(d, eq);
		// last edge; low kept past the reply delay and the pin synchroniser,
		// so the line never glitches high before the reply pull-down takes over
		pull_low <= 1'b1;
		wait_cyc(16);
		pull_low <= 1'b0;
	endtask : send_frame

	// power-save only by a long low after the frame
	task automatic hold_low(input int n);
		pull_low <= 1'b1;
		wait_cyc(n);
		pull_low <= 1'b0;
	endtask : hold_low
endmodule : ovs_master

// ---- tb/ovs_link_bench.sv ----
// bench for the one-pin voltage-set link receiver
`timescale 1ns/1ns
module ovs_link_bench;
	localparam int unsigned TMO = 400;
	localparam logic [7:0]  ID  = ovs_pkg::DEV_ID_RST;
	logic                   pclk, presetn, psel, penable, pwrite;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, r;
	logic                   pready, pslverr, oe, pwm, mst_low, err, dout;
	logic [4:0]             e0, e1, e2;
	wire logic              pin;
	ovs_pkg::ovs_settings_t settings;
	int                     fails, comparisons;

	// pull-up: low only while a side pulls down
	assign pin = !mst_low && (!oe || dout);

	ovs_link #(
		.TIMEOUT_CYC(TMO),
		.REPLY_PULSE_CYC(50),
		.REPLY_DELAY_CYC(10),
		.BUF_DEPTH(2)
	) i_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mode_data_in(pin),
		.mode_data_out(dout),
		.mode_data_oe(oe),
		.forced_pwm(pwm),
		.settings(settings)
	);

	ovs_master i_mst (
		.pclk(pclk),
		.pull_low(mst_low)
	);

	initial pclk = 1'b0;
	always #4 pclk = ~pclk;

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 16)
			begin
				fails++;
				report_and_stop();
			end
			@(posedge pclk);
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(r, exp);
	endtask : rd_chk

	task automatic chk_set();
		check({17'h0, settings}, {17'h0, e0, e1, e2});
	endtask : chk_set

	// sends a frame, then looks at the line once the master has let go
	task automatic frame(input logic [7:0] a, input logic [7:0] d, input int eq, input logic ack);
		i_mst.send_frame(a, d, eq);
		repeat (5) @(posedge pclk);
		check({31'h0, pin}, {31'h0, !ack});
		check({31'h0, pwm}, 32'h1);
		repeat (60) @(posedge pclk);
		check({31'h0, pin}, 32'h1);
	endtask : frame

	initial
	begin
		repeat (100000) @(posedge pclk);
		fails++;
		report_and_stop();
	end

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{fails, comparisons} = '0;
		{e0, e1, e2} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(ovs_pkg::OFF_CTRL, {16'h0, ID, 7'h0, ovs_pkg::CTRL_EN_RST});
		rd_chk(ovs_pkg::OFF_SET2, 32'h0);
		apb(1'b1, 8'h40, 32'hffffffff);
		check({31'h0, err}, 32'h1);
		rd_chk(8'h40, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test registers done");
		repeat (6) @(posedge pclk);
		check({31'h0, pwm}, 32'h1);
		$display("test mode done");
		frame(ID, 8'hb5, 0, 1'b1);
		e1 = 5'h15;
		chk_set();
		frame(ID, 8'h4a, 0, 1'b0);
		e2 = 5'h0a;
		chk_set();
		frame(ID, 8'h07, 0, 1'b0);
		e0 = 5'h07;
		chk_set();
		$display("test frames done");
		// buffer holds two frames, third overflows
		rd_chk(ovs_pkg::OFF_STATUS, 32'h39);
		apb(1'b1, ovs_pkg::OFF_STATUS, 32'h2c);
		rd_chk(ovs_pkg::OFF_STATUS, 32'h11);
		rd_chk(ovs_pkg::OFF_FRAME, 32'h1b5);
		rd_chk(ovs_pkg::OFF_FRAME, 32'h14a);
		rd_chk(ovs_pkg::OFF_FRAME, 32'h0);
		$display("test buffer done");
		frame(8'h33, 8'h9f, 0, 1'b0);
		frame(ID, 8'h9f, 1, 1'b0);
		chk_set();
		rd_chk(ovs_pkg::OFF_STATUS, 32'h05);
		$display("test refused frames done");
		i_mst.hold_low(TMO + 20);
		check({31'h0, pwm}, 32'h0);
		repeat (6) @(posedge pclk);
		check({31'h0, pwm}, 32'h1);
		chk_set();
		$display("test timeout done");
		// receiver disabled: the stream is ignored
		apb(1'b1, ovs_pkg::OFF_CTRL, 32'h00003300);
		frame(8'h33, 8'h1f, 0, 1'b0);
		chk_set();
		apb(1'b1, ovs_pkg::OFF_CTRL, 32'h00003301);
		frame(8'h33, 8'h1f, 0, 1'b0);
		e0 = 5'h1f;
		chk_set();
		frame(8'h33, 8'h6e, 0, 1'b0);
		chk_set();
		rd_chk(ovs_pkg::OFF_FRAME, 32'h11f);
		rd_chk(ovs_pkg::OFF_FRAME, 32'h16e);
		$display("test enable and address done");
		report_and_stop();
	end
endmodule : ovs_link_bench
